/* File: rtl/cpisp_path.sv */
// one complex path: premodulator then nine-tap complex inverse-sinc FIR
// assumes valid-qualified samples on clk from the data-port FIFO
`include "cpisp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cpisp_path (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // configuration
   input wire cpisp_pkg::cpisp_mode_t mode,
   input wire cpisp_pkg::cpisp_coefset_t coefs,
   // sample stream in
   input wire logic in_valid,
   input wire cpisp_pkg::cpisp_iq_t in_data,
   // sample stream out
   output logic out_valid,
   output cpisp_pkg::cpisp_iq_t out_data
);

   localparam int W = `CPISP_SAMPLE_W;
   localparam int AW = `CPISP_ACC_W;
   localparam int N = `CPISP_TAPS;

   logic sign_r;
   cpisp_pkg::cpisp_iq_t pm_r;
   logic pm_valid_r;
   logic signed [W-1:0] dl_i_r [N];
   logic signed [W-1:0] dl_q_r [N];
   logic dl_valid_r;
   logic signed [AW-1:0] yi_r;
   logic signed [AW-1:0] yq_r;
   logic out_valid_r;
   cpisp_pkg::cpisp_iq_t out_r;
   logic signed [9:0] hre [N];
   logic signed [9:0] him [N];
   logic signed [AW-1:0] sum_ii;
   logic signed [AW-1:0] sum_qq;
   logic signed [AW-1:0] sum_iq;
   logic signed [AW-1:0] sum_qi;
   logic signed [AW-1:0] yi_nxt;
   logic signed [AW-1:0] yq_nxt;

   // alternate sign per accepted sample, negating every second one
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sign_r <= 1'b0;
      end else if (ce && in_valid) begin
         sign_r <= ~sign_r;
      end
   end

   // premodulation: multiply by +1, -1, +1 ... shifts by half the rate
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pm_r <= '0;
         pm_valid_r <= 1'b0;
      end else if (ce) begin
         pm_valid_r <= in_valid;
         if (in_valid) begin
            if (mode.premod_en && sign_r) begin
               pm_r.i <= W'(-in_data.i);
               pm_r.q <= W'(-in_data.q);
            end else begin
               pm_r <= in_data;
            end
         end
      end
   end

   // tap delay line advanced once per input-rate sample
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int k = 0; k < N; k++) begin
            dl_i_r[k] <= '0;
            dl_q_r[k] <= '0;
         end
         dl_valid_r <= 1'b0;
      end else if (ce) begin
         dl_valid_r <= pm_valid_r;
         if (pm_valid_r) begin
            dl_i_r[0] <= pm_r.i;
            dl_q_r[0] <= pm_r.q;
            for (int k = 1; k < N; k++) begin
               dl_i_r[k] <= dl_i_r[k-1];
               dl_q_r[k] <= dl_q_r[k-1];
            end
         end
      end
   end

   // conjugate-symmetric tap coefficients, sign-extended
   always_comb begin
      hre[0] = 10'(coefs.c0_re);
      him[0] = 10'(coefs.c0_im);
      hre[1] = 10'(coefs.c1_re);
      him[1] = 10'(coefs.c1_im);
      hre[2] = 10'(coefs.c2_re);
      him[2] = 10'(coefs.c2_im);
      hre[3] = 10'(coefs.c3_re);
      him[3] = 10'(coefs.c3_im);
      hre[4] = coefs.c4_re;
      him[4] = coefs.c4_im;
      for (int k = 5; k < N; k++) begin
         hre[k] = hre[N-1-k];
         him[k] = 10'(-him[N-1-k]);
      end
   end

   // four real filters: real and imaginary coefficient sets on I and Q
   always_comb begin
      sum_ii = '0;
      sum_qq = '0;
      sum_iq = '0;
      sum_qi = '0;
      for (int k = 0; k < N; k++) begin
         // widen both operands first so the product never stops at sample width
         sum_ii = AW'(sum_ii + AW'(dl_i_r[k]) * AW'(hre[k]));
         sum_qq = AW'(sum_qq + AW'(dl_q_r[k]) * AW'(him[k]));
         sum_iq = AW'(sum_iq + AW'(dl_i_r[k]) * AW'(him[k]));
         sum_qi = AW'(sum_qi + AW'(dl_q_r[k]) * AW'(hre[k]));
      end
      if (mode.filt_en && !mode.real_mode) begin
         yi_nxt = AW'(sum_ii - sum_qq);
         yq_nxt = AW'(sum_iq + sum_qi);
      end else begin
         // bypass keeps I and Q separate, centre tap aligned with filter delay
         yi_nxt = AW'(dl_i_r[4]) <<< `CPISP_OUT_SHIFT;
         yq_nxt = AW'(dl_q_r[4]) <<< `CPISP_OUT_SHIFT;
      end
   end

   // accumulate stage register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         yi_r <= '0;
         yq_r <= '0;
         out_valid_r <= 1'b0;
      end else if (ce) begin
         out_valid_r <= dl_valid_r;
         if (dl_valid_r) begin
            yi_r <= yi_nxt;
            yq_r <= yq_nxt;
         end
      end
   end

   // scale back to sample width with saturation
   function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
      logic signed [AW-1:0] s;
      s = v >>> `CPISP_OUT_SHIFT;
      if (s > 32'sh0000_7fff) begin
         sat = 16'sh7fff;
      end else if (s < 32'shffff_8000) begin
         sat = 16'sh8000;
      end else begin
         sat = W'(s);
      end
   endfunction

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_r <= '0;
         out_valid <= 1'b0;
      end else if (ce) begin
         out_valid <= out_valid_r;
         if (out_valid_r) begin
            out_r.i <= sat(yi_r);
            out_r.q <= sat(yq_r);
         end
      end
   end

   assign out_data = out_r;

endmodule

`default_nettype wire

/* File: rtl/cpisp_consts.svh */
// constants for the complex premodulation and inverse-sinc path
// assumes inclusion by bare name from the package and the design modules
//
// Functional notes
// - two independent complex paths feed four converters
// - complex mode allows every stage without restriction
// - real mode: premod only, no I/Q mixing
// - premod negates every second sample, both channels
// - premod shifts spectrum up by half sample rate
// - compensation filter runs at input sample rate
// - nine-tap complex FIR, five conjugate-symmetric coefficients
// - taps 5..8 use conjugates of c3..c0
// - full complex product mixes I and Q
// - coefficients are signed two's-complement register values
// - coefficient widths 3,4,5,7,10 bits per part
// - four parallel real filters: two real, two imaginary
`ifndef CPISP_CONSTS_SVH
`define CPISP_CONSTS_SVH

`define CPISP_SAMPLE_W 16
`define CPISP_TAPS 9
`define CPISP_C0_W 3
`define CPISP_C1_W 4
`define CPISP_C2_W 5
`define CPISP_C3_W 7
`define CPISP_C4_W 10
`define CPISP_COEF_BASE 8'h20
`define CPISP_COEF_LAST 8'h27
`define CPISP_ACC_W 32
`define CPISP_OUT_SHIFT 9
`define CPISP_LATENCY 3

`endif

/* File: rtl/cpisp_pkg.sv */
// types shared by the premodulation and inverse-sinc path
// assumes cpisp_consts.svh on the include path
`include "cpisp_consts.svh"

package cpisp_pkg;

   // one complex sample, in-phase and quadrature
   typedef struct packed {
      logic signed [`CPISP_SAMPLE_W-1:0] i;
      logic signed [`CPISP_SAMPLE_W-1:0] q;
   } cpisp_iq_t;

   // one complex coefficient part set, each part sign-extended to ten bits
   typedef struct packed {
      logic signed [`CPISP_C4_W-1:0] re;
      logic signed [`CPISP_C4_W-1:0] im;
   } cpisp_coef_t;

   // full coefficient set c0..c4 held as native-width fields
   typedef struct packed {
      logic signed [`CPISP_C4_W-1:0] c4_re;
      logic signed [`CPISP_C4_W-1:0] c4_im;
      logic signed [`CPISP_C3_W-1:0] c3_re;
      logic signed [`CPISP_C3_W-1:0] c3_im;
      logic signed [`CPISP_C2_W-1:0] c2_re;
      logic signed [`CPISP_C2_W-1:0] c2_im;
      logic signed [`CPISP_C1_W-1:0] c1_re;
      logic signed [`CPISP_C1_W-1:0] c1_im;
      logic signed [`CPISP_C0_W-1:0] c0_re;
      logic signed [`CPISP_C0_W-1:0] c0_im;
   } cpisp_coefset_t;

   // per-path mode bits
   typedef struct packed {
      logic premod_en;
      logic filt_en;
      logic real_mode;
   } cpisp_mode_t;

endpackage

/* File: rtl/cpisp_top.sv */
// two complex paths driving four converter sample streams
// assumes coefficients loaded by the host via the device register port
`include "cpisp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cpisp_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // configuration from the register port
   input wire cpisp_pkg::cpisp_mode_t mode_a,
   input wire cpisp_pkg::cpisp_mode_t mode_b,
   input wire cpisp_pkg::cpisp_coefset_t coefs,
   // input streams
   input wire logic in_valid,
   input wire cpisp_pkg::cpisp_iq_t in_a,
   input wire cpisp_pkg::cpisp_iq_t in_b,
   // output streams to the interpolation chain
   output logic out_valid,
   output cpisp_pkg::cpisp_iq_t out_a,
   output cpisp_pkg::cpisp_iq_t out_b
);

   logic va;
   logic vb;
   cpisp_pkg::cpisp_coefset_t coef_r;

   // coefficient holding registers, loaded from the register port each cycle that ce is high
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         coef_r <= '0;
      end else if (ce) begin
         coef_r <= coefs;
      end
   end

   // two identical paths share one coefficient set and latency
   cpisp_path u_path_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .mode(mode_a),
      .coefs(coef_r),
      .in_valid(in_valid),
      .in_data(in_a),
      .out_valid(va),
      .out_data(out_a)
   );

   cpisp_path u_path_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .mode(mode_b),
      .coefs(coef_r),
      .in_valid(in_valid),
      .in_data(in_b),
      .out_valid(vb),
      .out_data(out_b)
   );

   assign out_valid = va & vb;

endmodule

`default_nettype wire

/* File: verification/cpisp_src_model.sv */
// data-port fifo model feeding both paths
// assumes calls from the bench just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cpisp_src_model (
   // clock
   input wire logic clk,
   // samples to the paths
   output logic in_valid,
   output cpisp_pkg::cpisp_iq_t in_a,
   output cpisp_pkg::cpisp_iq_t in_b
);
   initial begin
      in_valid = 1'b0;
      in_a = '0;
      in_b = '0;
   end
   // one complex sample per cycle on both paths
   task automatic send(input cpisp_pkg::cpisp_iq_t a, input cpisp_pkg::cpisp_iq_t b);
      @(posedge clk);
      #1;
      in_valid = 1'b1;
      in_a = a;
      in_b = b;
   endtask
   // released data changes so no stale sample lingers
   task automatic idle();
      @(posedge clk);
      #1;
      in_valid = 1'b0;
      in_a = ~in_a;
      in_b = ~in_b;
   endtask
endmodule
`default_nettype wire

/* File: verification/cpisp_checker.sv */
// port checker for the premodulation and inverse-sinc path
// assumes bind onto cpisp_top
`timescale 1ns/1ps
`default_nettype none
module cpisp_checker (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // modes
   input wire cpisp_pkg::cpisp_mode_t mode_a,
   input wire cpisp_pkg::cpisp_mode_t mode_b,
   // streams
   input wire logic in_valid,
   input wire cpisp_pkg::cpisp_iq_t in_a,
   input wire cpisp_pkg::cpisp_iq_t in_b,
   input wire logic out_valid,
   input wire cpisp_pkg::cpisp_iq_t out_a,
   input wire cpisp_pkg::cpisp_iq_t out_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // sample taken, then three running cycles
   sequence s_take;
      in_valid && ce ##1 ce[*3];
   endsequence
   sequence s_skip;
      !in_valid && ce ##1 ce[*3];
   endsequence
   a_valid_latency: assert property (s_take |=> out_valid)
      else $error("output valid late");
   a_no_spurious: assert property (s_skip |=> !out_valid)
      else $error("output valid without sample");
   a_release_quiet: assert property ($fell(sys_rst) |-> (!out_valid)[*4])
      else $error("output soon after reset");
   a_ce_freeze: assert property (!ce |=> $stable(out_valid) && $stable(out_a))
      else $error("state moved with enable low");
   a_out_hold: assert property (!out_valid |-> $stable(out_a) && $stable(out_b))
      else $error("output changed without valid");
   a_bypass_delay: assert property ((ce && in_valid && mode_b == 3'h0)[*8] |=>
      out_b == $past(in_b, 8)) else $error("bypass path b wrong");
   a_real_nomix: assert property ((ce && in_valid && mode_a == 3'h3)[*8] |=>
      out_a == $past(in_a, 8)) else $error("real mode path a wrong");
   a_premod_flip: assert property ((ce && in_valid && mode_b == 3'h4 && $stable(in_b))[*8]
      |=> out_b.i == -$past(out_b.i)) else $error("premod sign not alternating");
endmodule
bind cpisp_top cpisp_checker u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .mode_a(mode_a),
   .mode_b(mode_b), .in_valid(in_valid), .in_a(in_a), .in_b(in_b), .out_valid(out_valid),
   .out_a(out_a), .out_b(out_b));
`default_nettype wire

/* File: verification/complex_premod_inverse_sinc_path_test.sv */
// self-checking bench for the premodulation and inverse-sinc path
// assumes the source model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module complex_premod_inverse_sinc_path_test;
   logic clk, sys_rst, ce, in_valid, out_valid;
   cpisp_pkg::cpisp_mode_t mode_a, mode_b;
   cpisp_pkg::cpisp_coefset_t coefs;
   cpisp_pkg::cpisp_iq_t in_a, in_b, out_a, out_b;
   cpisp_pkg::cpisp_iq_t qa[$], qb[$];
   int n_errors, n_checks;
   int re[9] = '{1, 3, 5, -7, 100, -7, 5, 3, 1};
   int im[9] = '{-2, -4, 6, 8, -9, -8, -6, 4, 2};
   cpisp_top dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .mode_a(mode_a), .mode_b(mode_b),
      .coefs(coefs), .in_valid(in_valid), .in_a(in_a), .in_b(in_b), .out_valid(out_valid),
      .out_a(out_a), .out_b(out_b));
   cpisp_src_model src (.clk(clk), .in_valid(in_valid), .in_a(in_a), .in_b(in_b));
   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // collect every output sample
   always @(posedge clk) begin
      if (out_valid === 1'b1) begin
         qa.push_back(out_a);
         qb.push_back(out_b);
      end
   end
   function automatic cpisp_pkg::cpisp_iq_t iq(input int i, input int q);
      iq.i = 16'(i);
      iq.q = 16'(q);
   endfunction
   task automatic cmp(input cpisp_pkg::cpisp_iq_t got, input cpisp_pkg::cpisp_iq_t exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_n(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input cpisp_pkg::cpisp_mode_t ma, input cpisp_pkg::cpisp_mode_t mb);
      // step off the clock edge before touching reset or the modes
      #1;
      sys_rst = 1'b1;
      mode_a = ma;
      mode_b = mb;
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      qa.delete();
      qb.delete();
      cmp(out_a, '0);
   endtask
   // impulse on each path with a frozen cycle behind it
   task automatic t_filter();
      do_reset(3'h2, 3'h6);
      src.send(iq(512, 0), iq(0, 512));
      src.send('0, '0);
      ce = 1'b0;
      @(posedge clk);
      #1 ce = 1'b1;
      repeat (7) src.send('0, '0);
      src.idle();
      repeat (10) @(posedge clk);
      cmp_n(qa.size(), 9);
      for (int k = 0; k < 9; k++) begin
         cmp(qa[k], iq(re[k], im[k]));
         cmp(qb[k], iq(-im[k], re[k]));
      end
   endtask
   // constant stream through the bypassed filter
   task automatic t_stream(input cpisp_pkg::cpisp_mode_t ma, input cpisp_pkg::cpisp_mode_t mb);
      int sa, sb;
      do_reset(ma, mb);
      repeat (10) src.send(iq(100, -50), iq(-7, 9));
      src.idle();
      repeat (10) @(posedge clk);
      cmp_n(qa.size(), 10);
      for (int n = 0; n < 10; n++) begin
         sa = (n < 4) ? 0 : ((ma.premod_en && n[0]) ? -1 : 1);
         sb = (n < 4) ? 0 : ((mb.premod_en && n[0]) ? -1 : 1);
         cmp(qa[n], iq(100 * sa, -50 * sa));
         cmp(qb[n], iq(-7 * sb, 9 * sb));
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #20000;
      n_errors++;
      test_done();
   end
   // main sequence
   initial begin
      n_errors = 0;
      n_checks = 0;
      ce = 1'b1;
      coefs = '{c4_re: 10'h064, c4_im: 10'h3f7, c3_re: 7'h79, c3_im: 7'h08, c2_re: 5'h05,
         c2_im: 5'h06, c1_re: 4'h3, c1_im: 4'hc, c0_re: 3'h1, c0_im: 3'h6};
      t_filter();
      // host reloads a new tap set with extreme codes; taps 5..8 are its conjugates
      re = '{2, -4, 10, -35, 401, -35, 10, -4, 2};
      im = '{3, -8, 15, -64, -512, 64, -15, 8, -3};
      #1 coefs = '{c4_re: 10'h191, c4_im: 10'h200, c3_re: 7'h5d, c3_im: 7'h40, c2_re: 5'h0a,
         c2_im: 5'h0f, c1_re: 4'hc, c1_im: 4'h8, c0_re: 3'h2, c0_im: 3'h3};
      t_filter();
      t_stream(3'h7, 3'h4);
      t_stream(3'h3, 3'h0);
      test_done();
   end
endmodule
`default_nettype wire
